/* rtl/pwmcfg_reload_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// auto-reload bytes, low byte at even index; both read ports registered
module pwmcfg_reload_mem (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  pwmcfg_mem_if.mem m
);
  import pwmcfg_pkg::*;
  logic [7:0] mem_r [NUM_BYTES];
  logic [7:0] mem_nxt [NUM_BYTES];
  logic [7:0] rdata_r, rdata_nxt;
  logic [15:0] word_r, word_nxt;

  always_comb begin
    for (int i = 0; i < NUM_BYTES; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    if (m.wr && (m.waddr < 4'(NUM_BYTES))) begin
      mem_nxt[m.waddr] = m.wdata;
    end
    rdata_nxt = (m.raddr < 4'(NUM_BYTES)) ? mem_r[m.raddr] : 8'h00;
    word_nxt = (m.chan < 3'(NUM_MOD)) ? {mem_r[{m.chan, 1'b1}], mem_r[{m.chan, 1'b0}]} : 16'h0000;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        mem_r[i] <= 8'h00;
      end
      rdata_r <= 8'h00;
      word_r <= 16'h0000;
    end else begin
      mem_r <= mem_nxt;
      rdata_r <= rdata_nxt;
      word_r <= word_nxt;
    end
  end

  assign m.rdata = rdata_r;
  assign m.word = word_r;
endmodule : pwmcfg_reload_mem
`default_nettype wire

/* rtl/pwmcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reload select 0 sends compare-address accesses to the normal compare registers, 1 to the auto-reload registers.
// - auto-reload contents serve as reload value only for channels running 9, 10 or 11 bit cycles.
// - the array interrupt is requested from the overflow flag only while its enable bit is 1.
// - the overflow flag is set when counter bit 7, 8, 9 or 10 overflows, picked by the cycle length field.
// - the overflow flag is set by hardware or a written 1, and only a written 0 clears it.
// - bits four to two read as zero and ignore writes.
// - cycle length codes 00, 01, 10, 11 give 8, 9, 10, 11 bit cycles.
// - the cycle length applies to every channel not in 16 bit mode and is ignored by 16 bit channels.
// - each module's wide pwm enable picks 16 bit pwm when set and the shared cycle length when clear.
module pwmcfg_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_resetn,
  // special function register port
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // normal compare registers outside
  output logic o_cmp_wr,
  output logic o_cmp_rd,
  output logic [3:0] o_cmp_index,
  output logic [7:0] o_cmp_wdata,
  input wire logic [7:0] i_cmp_rdata,
  // main counter and modules
  input wire logic [15:0] i_main_array_counter,
  input wire logic i_counter_inc,
  input wire logic [pwmcfg_pkg::NUM_MOD-1:0] i_wide_pwm_enable,
  input wire logic [2:0] i_reload_chan,
  output logic [15:0] o_reload_value,
  output logic [pwmcfg_pkg::NUM_MOD-1:0] o_reload_use,
  output logic [pwmcfg_pkg::NUM_MOD-1:0] o_wide_mode,
  output logic [1:0] o_cycle_length_select,
  // interrupt
  input wire logic i_other_irq,
  output logic o_irq
);
  import pwmcfg_pkg::*;

  function automatic logic cycle_wrap(input logic [15:0] cnt, input logic [1:0] sel);
    logic w;
    w = 1'b0;
    case (sel)
      CYC_LEN_8: w = &cnt[7:0];
      CYC_LEN_9: w = &cnt[8:0];
      CYC_LEN_10: w = &cnt[9:0];
      default: w = &cnt[10:0];
    endcase
    return w;
  endfunction : cycle_wrap

  function automatic logic is_cmp(input logic [7:0] addr, input logic [7:0] page);
    return (page == CMP_PAGE) && (addr >= CMP_BASE) && (addr < CMP_BASE + 8'(NUM_BYTES));
  endfunction : is_cmp

  pwmcfg_mem_if mi ();

  pwmcfg_reload_mem u_mem (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .m(mi.mem)
  );

  logic rld_sel_r, rld_sel_nxt;
  logic ovf_irq_en_r, ovf_irq_en_nxt;
  logic ovf_flag_r, ovf_flag_nxt;
  logic [1:0] cyc_len_r, cyc_len_nxt;
  logic hit_reg, hit_cmp, ovf;
  logic [3:0] idx;
  pwmcfg_src_e src_r, src_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] regval_r, regval_nxt;
  logic cmp_wr_r, cmp_wr_nxt, cmp_rd_r, cmp_rd_nxt;
  logic [3:0] cmp_idx_r, cmp_idx_nxt;
  logic [7:0] cmp_wdata_r, cmp_wdata_nxt;
  logic irq_r, irq_nxt;
  logic [NUM_MOD-1:0] wide_r, wide_nxt, use_r, use_nxt;
  logic [15:0] reload_r, reload_nxt;

  assign hit_reg = (i_sfr_addr == PWMCFG_ADDR) && (i_sfr_page == PWMCFG_PAGE);
  assign hit_cmp = is_cmp(i_sfr_addr, i_sfr_page);
  assign idx = 4'(i_sfr_addr - CMP_BASE);
  assign ovf = i_counter_inc && cycle_wrap(i_main_array_counter, cyc_len_r);

  // configuration register
  always_comb begin
    rld_sel_nxt = rld_sel_r;
    ovf_irq_en_nxt = ovf_irq_en_r;
    cyc_len_nxt = cyc_len_r;
    ovf_flag_nxt = ovf_flag_r;
    if (i_sfr_wr && hit_reg) begin
      rld_sel_nxt = i_sfr_wdata[RLD_SEL_BIT];
      ovf_irq_en_nxt = i_sfr_wdata[OVF_IRQ_EN_BIT];
      cyc_len_nxt = i_sfr_wdata[CYC_LEN_LSB +: 2];
      ovf_flag_nxt = i_sfr_wdata[OVF_FLAG_BIT];
    end
    if (ovf) begin
      ovf_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rld_sel_r <= PWMCFG_RESET[RLD_SEL_BIT];
      ovf_irq_en_r <= PWMCFG_RESET[OVF_IRQ_EN_BIT];
      ovf_flag_r <= PWMCFG_RESET[OVF_FLAG_BIT];
      cyc_len_r <= PWMCFG_RESET[CYC_LEN_LSB +: 2];
    end else begin
      rld_sel_r <= rld_sel_nxt;
      ovf_irq_en_r <= ovf_irq_en_nxt;
      ovf_flag_r <= ovf_flag_nxt;
      cyc_len_r <= cyc_len_nxt;
    end
  end

  // access routing and two-stage read
  always_comb begin
    mi.wr = i_sfr_wr && hit_cmp && rld_sel_r;
    mi.waddr = idx;
    mi.wdata = i_sfr_wdata;
    mi.raddr = idx;
    mi.chan = i_reload_chan;
    cmp_wr_nxt = i_sfr_wr && hit_cmp && !rld_sel_r;
    cmp_rd_nxt = i_sfr_rd && hit_cmp && !rld_sel_r;
    cmp_idx_nxt = (hit_cmp && (i_sfr_wr || i_sfr_rd)) ? idx : cmp_idx_r;
    cmp_wdata_nxt = i_sfr_wr ? i_sfr_wdata : cmp_wdata_r;
    regval_nxt = {rld_sel_r, ovf_irq_en_r, ovf_flag_r, 3'h0, cyc_len_r};
    src_nxt = PWMCFG_SRC_NONE;
    if (i_sfr_rd && hit_reg) begin
      src_nxt = PWMCFG_SRC_REG;
    end else if (i_sfr_rd && hit_cmp && rld_sel_r) begin
      src_nxt = PWMCFG_SRC_MEM;
    end else if (i_sfr_rd && hit_cmp) begin
      src_nxt = PWMCFG_SRC_CMP;
    end
    case (src_r)
      PWMCFG_SRC_REG: rdata_nxt = regval_r;
      PWMCFG_SRC_MEM: rdata_nxt = mi.rdata;
      PWMCFG_SRC_CMP: rdata_nxt = i_cmp_rdata;
      default: rdata_nxt = rdata_r;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      src_r <= PWMCFG_SRC_NONE;
      rdata_r <= 8'h00;
      regval_r <= 8'h00;
      cmp_wr_r <= 1'b0;
      cmp_rd_r <= 1'b0;
      cmp_idx_r <= 4'h0;
      cmp_wdata_r <= 8'h00;
    end else begin
      src_r <= src_nxt;
      rdata_r <= rdata_nxt;
      regval_r <= regval_nxt;
      cmp_wr_r <= cmp_wr_nxt;
      cmp_rd_r <= cmp_rd_nxt;
      cmp_idx_r <= cmp_idx_nxt;
      cmp_wdata_r <= cmp_wdata_nxt;
    end
  end

  // per-channel mode, reload value and interrupt
  always_comb begin
    wide_nxt = i_wide_pwm_enable;
    use_nxt = ~i_wide_pwm_enable & {NUM_MOD{cyc_len_r != CYC_LEN_8}};
    reload_nxt = (i_reload_chan < 3'(NUM_MOD) && use_r[i_reload_chan]) ? mi.word : 16'h0000;
    irq_nxt = (ovf_flag_r && ovf_irq_en_r) || i_other_irq;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wide_r <= '0;
      use_r <= '0;
      reload_r <= 16'h0000;
      irq_r <= 1'b0;
    end else begin
      wide_r <= wide_nxt;
      use_r <= use_nxt;
      reload_r <= reload_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_sfr_rdata = rdata_r;
  assign o_cmp_wr = cmp_wr_r;
  assign o_cmp_rd = cmp_rd_r;
  assign o_cmp_index = cmp_idx_r;
  assign o_cmp_wdata = cmp_wdata_r;
  assign o_reload_value = reload_r;
  assign o_reload_use = use_r;
  assign o_wide_mode = wide_r;
  assign o_cycle_length_select = cyc_len_r;
  assign o_irq = irq_r;

  // assertions
  property p_irq_masked;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (!ovf_irq_en_r && !i_other_irq) |=> !o_irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq raised with overflow masked");

  property p_irq_raised;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (ovf_flag_r && ovf_irq_en_r) |=> o_irq;
  endproperty
  a_irq_raised: assert property (p_irq_raised) else $error("enabled overflow did not raise irq");

  property p_other_irq;
    @(posedge i_core_clk) disable iff (!i_resetn) i_other_irq |=> o_irq;
  endproperty
  a_other_irq: assert property (p_other_irq) else $error("other source not merged");

  property p_ovf_sets;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_counter_inc && cyc_len_r == CYC_LEN_9 && i_main_array_counter[8:0] == 9'h1ff) |=> ovf_flag_r;
  endproperty
  a_ovf_sets: assert property (p_ovf_sets) else $error("9 bit wrap did not set flag");

  property p_no_hw_clear;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (ovf_flag_r && !(i_sfr_wr && hit_reg)) |=> ovf_flag_r;
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared without a write");

  property p_unused_zero;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (src_r == PWMCFG_SRC_REG) |=> (o_sfr_rdata[4:2] == 3'h0);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits read nonzero");

  sequence s_cmp_wr_normal;
    i_sfr_wr && hit_cmp && !rld_sel_r;
  endsequence
  property p_route_normal;
    @(posedge i_core_clk) disable iff (!i_resetn) s_cmp_wr_normal |=> o_cmp_wr && !$past(mi.wr);
  endproperty
  a_route_normal: assert property (p_route_normal) else $error("normal compare write misrouted");

  property p_route_reload;
    @(posedge i_core_clk) disable iff (!i_resetn) (i_sfr_wr && hit_cmp && rld_sel_r) |=> !o_cmp_wr;
  endproperty
  a_route_reload: assert property (p_route_reload) else $error("reload write leaked to compare");

  property p_wide_no_reload;
    @(posedge i_core_clk) disable iff (!i_resetn)
      (i_wide_pwm_enable[0] || cyc_len_r == CYC_LEN_8) |=> !o_reload_use[0];
  endproperty
  a_wide_no_reload: assert property (p_wide_no_reload) else $error("reload used outside 9 to 11 bit");

  property p_wide_follow;
    @(posedge i_core_clk) disable iff (!i_resetn) 1'b1 |=> o_wide_mode == $past(i_wide_pwm_enable);
  endproperty
  a_wide_follow: assert property (p_wide_follow) else $error("wide mode not tracked");
endmodule : pwmcfg_top
`default_nettype wire

/* shared/pwmcfg_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pwmcfg_mem_if;
  logic wr;
  logic [3:0] waddr;
  logic [7:0] wdata;
  logic [3:0] raddr;
  logic [7:0] rdata;
  logic [2:0] chan;
  logic [15:0] word;
  modport ctrl (output wr, output waddr, output wdata, output raddr, output chan, input rdata, input word);
  modport mem (input wr, input waddr, input wdata, input raddr, input chan, output rdata, output word);
endinterface : pwmcfg_mem_if
`default_nettype wire

/* shared/pwmcfg_pkg.sv */
package pwmcfg_pkg;
  localparam logic [7:0] PWMCFG_ADDR = 8'hd9;
  localparam logic [7:0] PWMCFG_PAGE = 8'h0f;
  localparam logic [7:0] PWMCFG_RESET = 8'h00;
  localparam int RLD_SEL_BIT = 7;
  localparam int OVF_IRQ_EN_BIT = 6;
  localparam int OVF_FLAG_BIT = 5;
  localparam int CYC_LEN_LSB = 0;
  localparam logic [7:0] CMP_PAGE = 8'h00;
  localparam logic [7:0] CMP_BASE = 8'he0;
  localparam int NUM_MOD = 6;
  localparam int NUM_BYTES = 12;
  localparam logic [1:0] CYC_LEN_8 = 2'h0;
  localparam logic [1:0] CYC_LEN_9 = 2'h1;
  localparam logic [1:0] CYC_LEN_10 = 2'h2;
  localparam logic [1:0] CYC_LEN_11 = 2'h3;
  typedef enum logic [1:0] {PWMCFG_SRC_REG, PWMCFG_SRC_MEM, PWMCFG_SRC_CMP, PWMCFG_SRC_NONE} pwmcfg_src_e;
endpackage : pwmcfg_pkg

/* verif/test_pwmcfg_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t got %h want %h", $time, a, b); end end
module test_pwmcfg_top;
  import pwmcfg_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_sfr_addr, i_sfr_page, i_sfr_wdata, i_cmp_rdata, o_sfr_rdata, o_cmp_wdata;
  logic i_sfr_wr, i_sfr_rd, o_cmp_wr, o_cmp_rd, i_counter_inc, i_other_irq, o_irq;
  logic [3:0] o_cmp_index;
  logic [15:0] i_main_array_counter, o_reload_value, ones;
  logic [5:0] i_wide_pwm_enable, o_reload_use, o_wide_mode, wide;
  logic [2:0] i_reload_chan, ch;
  logic [1:0] o_cycle_length_select;
  logic [7:0] exp_q[$];
  logic [7:0] e, lo, hi, d, cr;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  int miscompares = 0;
  int total_checks = 0;

  always #50 i_core_clk = ~i_core_clk;

  pwmcfg_top i_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_sfr_addr(i_sfr_addr),
    .i_sfr_page(i_sfr_page), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .o_cmp_wr(o_cmp_wr), .o_cmp_rd(o_cmp_rd), .o_cmp_index(o_cmp_index),
    .o_cmp_wdata(o_cmp_wdata), .i_cmp_rdata(i_cmp_rdata), .i_main_array_counter(i_main_array_counter),
    .i_counter_inc(i_counter_inc), .i_wide_pwm_enable(i_wide_pwm_enable), .i_reload_chan(i_reload_chan),
    .o_reload_value(o_reload_value), .o_reload_use(o_reload_use), .o_wide_mode(o_wide_mode),
    .o_cycle_length_select(o_cycle_length_select), .i_other_irq(i_other_irq), .o_irq(o_irq));

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p, input logic [7:0] v);
    @(posedge i_core_clk);
    i_sfr_wr <= w;
    i_sfr_rd <= !w;
    i_sfr_addr <= a;
    i_sfr_page <= p;
    i_sfr_wdata <= v;
    @(posedge i_core_clk);
    i_sfr_wr <= 1'b0;
    i_sfr_rd <= 1'b0;
  endtask : acc

  task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] v);
    exp_q.push_back(v);
    acc(1'b0, a, p, 8'h00);
  endtask : rd

  task automatic tick(input logic [15:0] x);
    @(posedge i_core_clk);
    i_main_array_counter <= x;
    i_counter_inc <= 1'b1;
    @(posedge i_core_clk);
    i_counter_inc <= 1'b0;
  endtask : tick

  // read data lands one edge after the strobe is taken; compare on the edge after that
  always @(posedge i_core_clk) begin
    if (p2) begin
      e = exp_q.pop_front();
      `CHK(o_sfr_rdata, e)
    end
    p2 = p1;
    p1 = i_sfr_rd && ((i_sfr_addr == PWMCFG_ADDR && i_sfr_page == PWMCFG_PAGE) ||
      (i_sfr_page == CMP_PAGE && i_sfr_addr >= CMP_BASE && i_sfr_addr < CMP_BASE + 8'(NUM_BYTES)));
  end

  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end

  initial begin
    {i_sfr_wr, i_sfr_rd, i_counter_inc, i_other_irq} = 4'h0;
    {i_sfr_addr, i_sfr_page, i_sfr_wdata, i_cmp_rdata} = 32'h0;
    {i_main_array_counter, i_wide_pwm_enable, i_reload_chan} = 25'h0;
    void'($urandom(42379));
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rd(PWMCFG_ADDR, PWMCFG_PAGE, PWMCFG_RESET);
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'hff);
    rd(PWMCFG_ADDR, PWMCFG_PAGE, 8'he3);
    for (int c = 0; c < 4; c++) begin
      @(posedge i_core_clk);
      wide = 6'($urandom);
      i_wide_pwm_enable <= wide;
      acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'(c));
      ones = (16'h1 << (8 + c)) - 16'h1;
      // lower bits full but the selected bit not yet carrying
      tick((16'($urandom) | ones) & ~(16'h1 << (7 + c)));
      rd(PWMCFG_ADDR, PWMCFG_PAGE, 8'(c));
      tick(16'($urandom) | ones);
      rd(PWMCFG_ADDR, PWMCFG_PAGE, 8'h20 | 8'(c));
      #1 `CHK(o_cycle_length_select, 2'(c))
      `CHK(o_reload_use, (c != 0) ? ~wide : 6'h00)
      `CHK(o_wide_mode, wide)
    end
    `CHK(o_irq, 1'b0)
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h63);
    repeat (2) @(posedge i_core_clk);
    #1 `CHK(o_irq, 1'b1)
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h43);
    rd(PWMCFG_ADDR, PWMCFG_PAGE, 8'h43);
    #1 `CHK(o_irq, 1'b0)
    @(posedge i_core_clk);
    i_other_irq <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 `CHK(o_irq, 1'b1)
    @(posedge i_core_clk);
    i_other_irq <= 1'b0;
    ch = 3'($urandom_range(5));
    lo = 8'($urandom);
    hi = 8'($urandom);
    i_reload_chan <= ch;
    i_wide_pwm_enable <= 6'h00;
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h81);
    acc(1'b1, CMP_BASE + 8'(2 * ch), CMP_PAGE, lo);
    #1 `CHK(o_cmp_wr, 1'b0)
    acc(1'b1, CMP_BASE + 8'(2 * ch + 1), CMP_PAGE, hi);
    rd(CMP_BASE + 8'(2 * ch), CMP_PAGE, lo);
    rd(CMP_BASE + 8'(2 * ch + 1), CMP_PAGE, hi);
    repeat (4) @(posedge i_core_clk);
    #1 `CHK(o_reload_value, {hi, lo})
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h80);
    repeat (4) @(posedge i_core_clk);
    #1 `CHK(o_reload_value, 16'h0000)
    d = 8'($urandom);
    cr = 8'($urandom);
    @(posedge i_core_clk);
    i_cmp_rdata <= cr;
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h01);
    acc(1'b1, CMP_BASE + 8'h05, CMP_PAGE, d);
    #1 `CHK({o_cmp_wr, o_cmp_index, o_cmp_wdata}, {1'b1, 4'h5, d})
    rd(CMP_BASE + 8'h05, CMP_PAGE, cr);
    #1 `CHK({o_cmp_rd, o_cmp_index}, {1'b1, 4'h5})
    acc(1'b0, 8'h10, 8'h00, 8'h00);
    // an unmapped read gives no answer, so the last read data must stay
    repeat (2) @(posedge i_core_clk);
    #1 `CHK(o_sfr_rdata, cr)
    acc(1'b1, PWMCFG_ADDR, PWMCFG_PAGE, 8'h81);
    rd(CMP_BASE + 8'h05, CMP_PAGE, (ch == 3'h2) ? hi : 8'h00);
    repeat (4) @(posedge i_core_clk);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : test_pwmcfg_top
`undef CHK
`default_nettype wire
